// ===== dv/pka_regs_properties.sv
// Purpose: concurrent checks on the ability register bank ports
// Assumes: one mclk domain, synchronous active-low reset
// Notes:   bound to every pka_regs instance
`timescale 1ns/10ps
module pka_regs_chk
    import pka_pkg::*;
(
    input wire logic        mclk,          // management clock
    input wire logic        nrst,          // reset, low
    input wire logic [2:0]  mode_strap,    // mode straps
    input wire logic        mdc,           // management data clock
    input wire logic        mdio_o,        // data out
    input wire logic        mdio_oe,       // drive enable
    input wire logic        an_restart,    // negotiation restart
    input wire logic        an_done,       // negotiation complete
    input wire logic        lcw_valid,     // code word strobe
    input wire logic [15:0] lcw_data,      // code word
    input wire logic [15:0] adv_word,      // advertisement register
    input wire logic [15:0] partner_word,  // partner register
    input wire logic        pause_sym_en,  // symmetric pause
    input wire logic        pause_asym_en  // asymmetric pause
);
    logic       mdc_q;    // mdc one cycle ago
    logic [4:0] rises_q;  // mdc rises while answering

    // count mdc rises inside one read answer
    always_ff @(posedge mclk) begin
        mdc_q <= mdc;
        if (!nrst || !mdio_oe) begin
            rises_q <= 5'h00;
        end else if (mdc && !mdc_q) begin
            rises_q <= rises_q + 5'h01;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence ta_start_s;
        $rose(mdio_oe) ##0 (mdio_o == 1'b0);
    endsequence
    sequence code_word_s;
        lcw_valid;
    endsequence

    lp_capture_a: assert property (code_word_s |=>
        partner_word == (($past(lcw_data) & 16'hA7E0) | 16'h4001))
        else $error("partner word not taken from code word");
    lp_restart_a: assert property (an_restart && !lcw_valid |=>
        partner_word == 16'h0001)
        else $error("partner word not cleared by restart");
    lp_hold_a: assert property (!lcw_valid && !an_restart |=>
        $stable(partner_word))
        else $error("partner word changed without cause");
    lp_fixed_a: assert property (partner_word[4:0] == 5'h01 &&
        partner_word[12:11] == 2'h0)
        else $error("partner selector or reserved bits wrong");
    adv_reserved_a: assert property (adv_word[15:14] == 2'h0 &&
        adv_word[12] == 1'b0 && adv_word[9] == 1'b0)
        else $error("advertisement reserved bits not zero");
    adv_reset_a: assert property (!$past(nrst) |-> adv_word ==
        ($past(mode_strap) == 3'h7 ? 16'h01E1 : 16'h0081))
        else $error("advertisement reset value wrong");
    pause_idle_a: assert property (!an_done |=>
        !pause_sym_en && !pause_asym_en)
        else $error("pause enabled before negotiation done");
    pause_one_a: assert property (!(pause_sym_en && pause_asym_en))
        else $error("both pause kinds enabled");
    pause_asym_a: assert property (an_done && adv_word[11:10] == 2'h2
        |=> pause_asym_en && !pause_sym_en)
        else $error("asymmetric pause not resolved");
    ta_drive_a: assert property (ta_start_s |=> mdio_oe [*8])
        else $error("read answer dropped early");
    drive_len_a: assert property ($fell(mdio_oe) |-> rises_q == 5'h11)
        else $error("read answer length wrong");
endmodule

bind pka_regs pka_regs_chk chk (.mclk, .nrst, .mode_strap, .mdc, .mdio_o,
    .mdio_oe, .an_restart, .an_done, .lcw_valid, .lcw_data, .adv_word,
    .partner_word, .pause_sym_en, .pause_asym_en);

// ===== dv/pka_smc.sv
// Purpose: station management controller driving mdc and mdio
// Assumes: mdc halves of three mclk cycles, pull-up on mdio
// Notes:   mdc stands high between frames
`timescale 1ns/10ps
module pka_smc
    import pka_pkg::*;
(
    input  wire logic mclk,     // management clock
    input  wire logic mdio_o,   // device data out
    input  wire logic mdio_oe,  // device drive enable
    output logic      mdc,      // management data clock
    output logic      mdio_i    // resolved mdio wire
);
    logic drv_q;  // controller drives the line
    logic bit_q;  // level driven by controller

    initial begin
        mdc = 1'b1;
        drv_q = 1'b0;
        bit_q = 1'b1;
    end

    // pull-up holds the line high when nobody drives
    assign mdio_i = mdio_oe ? mdio_o : (drv_q ? bit_q : 1'b1);

    // one mdc period, wire sampled late in the low half
    task automatic cyc(input logic b, input logic d, output logic s);
        @(posedge mclk);
        mdc <= 1'b0;
        drv_q <= d;
        bit_q <= b;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        s = mdio_i;
        @(posedge mclk);
        mdc <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] idx, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [63:0] f;
        logic        s;
        f = {32'hFFFFFFFF, 2'b01, op, pa, idx, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            cyc(f[i], (op == OP_WRITE) || (i > 17), s);
            if (i < 16) begin
                rd[i] = s;
            end
        end
        @(posedge mclk);
        drv_q <= 1'b0;
    endtask
endmodule

// ===== dv/test_phy_autoneg_ability_regs.sv
// Purpose: self-checking bench for the ability register bank
// Assumes: register traffic only through the management frames
// Notes:   identity values below are arbitrary
`timescale 1ns/10ps
module test_phy_autoneg_ability_regs;
    import pka_pkg::*;
    localparam logic [15:0] ID_RST = {6'h15, 6'h2A, 4'h1}; // arbitrary
    logic        mclk, nrst, mdc, mdio_i, mdio_o, mdio_oe;
    logic        an_restart, an_done, lcw_valid, sym, asym;
    logic        pause_sym_en, pause_asym_en;
    logic [2:0]  mode_strap;
    logic [4:0]  addr;
    logic [15:0] lcw_data, adv_word, partner_word, adv_m, id_m, lp_m, d, x;
    int          num_errors, checked;

    pka_regs #(.ORG_BITS(6'h15), .MODEL(6'h2A), .REVISION(4'h1)) dut (
        .mclk, .nrst, .mode_strap, .phy_addr(addr), .mdc, .mdio_i,
        .mdio_o, .mdio_oe, .an_restart, .an_done, .lcw_valid, .lcw_data,
        .adv_word, .partner_word, .pause_sym_en, .pause_asym_en);
    pka_smc smc (.mclk, .mdio_o, .mdio_oe, .mdc, .mdio_i);

    // free-running management clock
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    task automatic cmp16(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] pa, input logic [4:0] idx,
                      input logic [15:0] v);
        logic [15:0] r;
        smc.frame(OP_WRITE, pa, idx, v, r);
    endtask
    task automatic rdc(input string n, input logic [4:0] pa,
                       input logic [4:0] idx, input logic [15:0] e);
        logic [15:0] r;
        smc.frame(OP_READ, pa, idx, 16'h0000, r);
        cmp16(n, e, r);
    endtask
    task automatic do_reset();
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask
    // one received code word, expected partner view updated
    task automatic code_word(input logic [15:0] v);
        @(posedge mclk);
        lcw_data <= v;
        lcw_valid <= 1'b1;
        @(posedge mclk);
        lcw_valid <= 1'b0;
        lp_m = (v & 16'hA7E0) | 16'h4001;
        @(posedge mclk);
        cmp16("partner_word", lp_m, partner_word);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (80000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        void'($urandom(68));
        nrst = 1'b0;
        mode_strap = STRAP_ALL;
        addr = 5'($urandom);
        an_restart = 1'b0;
        an_done = 1'b0;
        lcw_valid = 1'b0;
        lcw_data = 16'h0000;
        num_errors = 0;
        checked = 0;
        do_reset();
        adv_m = 16'h01E1;
        id_m = ID_RST;
        lp_m = 16'h0001;
        cmp16("adv_word", adv_m, adv_word);
        rdc("adv", addr, IDX_ADVERTISE, adv_m);
        rdc("ident", addr, IDX_IDENT_LOW, id_m);
        rdc("partner", addr, IDX_PARTNER, lp_m);
        // advertisement writes, every pause code then random words
        for (int k = 0; k < 6; k++) begin
            d = 16'($urandom);
            if (k < 4) d[11:10] = 2'(k);
            wr(addr, IDX_ADVERTISE, d);
            adv_m = d & 16'h2DFF;
            rdc("adv", addr, IDX_ADVERTISE, adv_m);
            cmp16("adv_word", adv_m, adv_word);
        end
        d = 16'($urandom);
        wr(addr, IDX_IDENT_LOW, d);
        id_m = d;
        rdc("ident", addr, IDX_IDENT_LOW, id_m);
        wr(addr, IDX_PARTNER, 16'($urandom));
        rdc("partner", addr, IDX_PARTNER, lp_m);
        rdc("unmapped", addr, 5'h06, 16'hFFFF);
        rdc("other addr", addr ^ 5'h01, IDX_ADVERTISE, 16'hFFFF);
        wr(addr ^ 5'h01, IDX_ADVERTISE, ~adv_m);
        rdc("adv", addr, IDX_ADVERTISE, adv_m);
        for (int k = 0; k < 3; k++) begin
            code_word(16'($urandom));
        end
        rdc("partner", addr, IDX_PARTNER, lp_m);
        // every pause code against both partner answers
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                d = {adv_m[15:12], 2'(c), adv_m[9:0]};
                wr(addr, IDX_ADVERTISE, d);
                adv_m = d;
                code_word({5'h00, p[0], 10'h000});
                an_done <= 1'b1;
                repeat (3) @(posedge mclk);
                sym = (c == 1 || c == 3) && p == 1;
                asym = c == 2 || (c == 3 && p == 0);
                cmp16("pause", {14'h0, sym, asym},
                      {14'h0, pause_sym_en, pause_asym_en});
                an_done <= 1'b0;
                repeat (3) @(posedge mclk);
                cmp16("pause idle", 16'h0000,
                      {14'h0, pause_sym_en, pause_asym_en});
            end
        end
        // a code word in the restart cycle is kept
        @(posedge mclk);
        an_restart <= 1'b1;
        lcw_data <= 16'h0400;
        lcw_valid <= 1'b1;
        @(posedge mclk);
        an_restart <= 1'b0;
        lcw_valid <= 1'b0;
        @(posedge mclk);
        cmp16("partner_word", 16'h4401, partner_word);
        @(posedge mclk);
        an_restart <= 1'b1;
        @(posedge mclk);
        an_restart <= 1'b0;
        lp_m = 16'h0001;
        rdc("partner", addr, IDX_PARTNER, lp_m);
        mode_strap <= 3'($urandom_range(6, 0));
        do_reset();
        cmp16("adv_word", 16'h0081, adv_word);
        rdc("ident", addr, IDX_IDENT_LOW, ID_RST);
        rdc("partner", addr, IDX_PARTNER, 16'h0001);
        report_and_stop();
    end
endmodule

// ===== rtl/pka_partner_latch.sv
// Purpose: holds the ability word received from the link partner
// Assumes: lcw_valid pulses once per received base link code word
// Notes:   cleared by reset or by a restart of auto-negotiation
`timescale 1ns/10ps
module pka_partner_latch
    import pka_pkg::*;
(
    input  wire logic        mclk,        // management clock
    input  wire logic        nrst,        // synchronous reset, low
    input  wire logic        an_restart,  // clears partner view
    input  wire logic        lcw_valid,   // link code word received
    input  wire logic [15:0] lcw_data,    // received base page
    output logic      [15:0] lp_word      // partner register value
);
    logic [15:0] lp_q;

    // capture partner abilities; reserved bits kept at zero
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lp_q <= LP_RESET;
        end else if (lcw_valid) begin
            lp_q                 <= LP_RESET;
            lp_q[LP_NEXT]        <= lcw_data[LP_NEXT];
            lp_q[LP_ACK]         <= 1'b1;
            lp_q[LP_RFAULT]      <= lcw_data[LP_RFAULT];
            lp_q[LP_PAUSE]       <= lcw_data[LP_PAUSE];
            lp_q[LP_T4]          <= lcw_data[LP_T4];
            lp_q[8:LP_ABIL_LSB]  <= lcw_data[8:LP_ABIL_LSB];
        end else if (an_restart) begin
            // a code word arriving in the restart cycle outranks the clear
            lp_q <= LP_RESET;
        end
    end

    assign lp_word = {lp_q[15:5], SELECTOR_8023};
endmodule

// ===== rtl/pka_pause_resolve.sv
// Purpose: resolves advertised pause into one active pause kind
// Assumes: an_done stays high while negotiation is complete
// Notes:   both enables are low until negotiation completes
`timescale 1ns/10ps
module pka_pause_resolve
    import pka_pkg::*;
(
    input  wire logic       mclk,          // management clock
    input  wire logic       nrst,          // synchronous reset, low
    input  wire logic       an_done,       // negotiation complete
    input  wire logic [1:0] local_pause,   // advertised pause code
    input  wire logic       partner_pause, // partner supports pause
    output logic            pause_sym_en,  // symmetric pause in use
    output logic            pause_asym_en  // asymmetric pause in use
);
    logic sym_d;
    logic asym_d;

    always_comb begin
        sym_d  = 1'b0;
        asym_d = 1'b0;
        case (local_pause)
            PAUSE_SYM:  sym_d  = partner_pause;
            PAUSE_ASYM: asym_d = 1'b1;
            PAUSE_BOTH: begin
                sym_d  = partner_pause;
                asym_d = !partner_pause;
            end
            default: begin
                sym_d  = 1'b0;
                asym_d = 1'b0;
            end
        endcase
    end

    // register the outcome only while negotiation is complete
    always_ff @(posedge mclk) begin
        if (!nrst || !an_done) begin
            pause_sym_en  <= 1'b0;
            pause_asym_en <= 1'b0;
        end else begin
            pause_sym_en  <= sym_d;
            pause_asym_en <= asym_d;
        end
    end
endmodule

// ===== rtl/pka_pkg.sv
// Purpose: constants and types shared by the ability register bank
// Assumes: 16-bit management registers reached by 5-bit index
// Notes:   indices, field positions and reset values live here, except the identifier reset parameters of pka_regs
package pka_pkg;
    // register indices on the serial management interface
    localparam logic [4:0]  IDX_IDENT_LOW  = 5'h03;
    localparam logic [4:0]  IDX_ADVERTISE  = 5'h04;
    localparam logic [4:0]  IDX_PARTNER    = 5'h05;
    // second identifier register fields
    localparam int          ID_ORG_LSB     = 10;
    localparam int          ID_MODEL_LSB   = 4;
    localparam int          ID_REV_LSB     = 0;
    // advertisement register fields
    localparam int          ADV_RFAULT     = 13;
    localparam int          ADV_PAUSE_LSB  = 10;
    localparam int          ADV_100FD      = 8;
    localparam int          ADV_100        = 7;
    localparam int          ADV_10FD       = 6;
    localparam int          ADV_10         = 5;
    localparam logic [15:0] ADV_WR_MASK    = 16'h2DFF;
    localparam logic [15:0] ADV_RESET_BASE = 16'h0081;
    // partner ability register fields
    localparam int          LP_NEXT        = 15;
    localparam int          LP_ACK         = 14;
    localparam int          LP_RFAULT      = 13;
    localparam int          LP_PAUSE       = 10;
    localparam int          LP_T4          = 9;
    localparam int          LP_ABIL_LSB    = 5;
    localparam logic [15:0] LP_RESET       = 16'h0001;
    localparam logic [4:0]  SELECTOR_8023  = 5'h01;
    // pause encodings
    localparam logic [1:0]  PAUSE_NONE     = 2'h0;
    localparam logic [1:0]  PAUSE_SYM      = 2'h1;
    localparam logic [1:0]  PAUSE_ASYM     = 2'h2;
    localparam logic [1:0]  PAUSE_BOTH     = 2'h3;
    // mode strap value that offers every speed ability
    localparam logic [2:0]  STRAP_ALL      = 3'h7;
    // management frame layout
    localparam logic [5:0]  PRE_LEN        = 6'h20;
    localparam logic [4:0]  HDR_LAST       = 5'h0C;
    localparam logic [4:0]  DATA_BITS      = 5'h10;
    localparam logic [4:0]  TA_LAST        = 5'h01;
    localparam logic [1:0]  OP_READ        = 2'h2;
    localparam logic [1:0]  OP_WRITE       = 2'h1;

    typedef enum logic [2:0] {
        PKA_S_PRE,
        PKA_S_HDR,
        PKA_S_TA,
        PKA_S_RDATA,
        PKA_S_WTA,
        PKA_S_WDATA
    } pka_state_t;
endpackage

// ===== rtl/pka_regs.sv
// Purpose: identifier, advertisement and partner ability registers
//          behind a serial management slave
// Assumes: mdc and mdio_i are synchronous to mclk and mdc runs well
//          below half the mclk rate
// Notes:   only indices 3, 4 and 5 answer; other indices stay silent
`timescale 1ns/10ps

// Function
// - identifier bits 15:10 give organization identifier bits 19-24
// - identifier bits 9:4 give a six-bit model number
// - identifier bits 3:0 give a revision set by silicon revision
// - advertisement bit 13 holds the local remote fault, reset zero
// - advertisement bits 11:10 encode pause ability, reset 00
// - with both pause kinds offered only one is used after negotiation
// - advertisement bits 8..5 select offered speeds, bit 7 resets one
// - reset values of advertisement bits 8, 6, 5 come from mode straps
// - bits 4:0 of both registers carry selector 00001, writable in one
// - partner bit 14 is read-only and set once a code word arrives
// - partner bit 13 is read-only and mirrors partner remote fault
// - partner bit 10 is read-only and shows partner pause support
// - partner bits 8..5 are read-only partner speed abilities
// - partner bit 15 is read-only partner next page ability
// - partner bit 9 is read-only partner T4 ability
// - registers are reached by index over the management interface
module pka_regs
    import pka_pkg::*;
#(
    parameter logic [5:0] ORG_BITS = 6'h15, // arbitrary identity value
    parameter logic [5:0] MODEL    = 6'h2A, // arbitrary identity value
    parameter logic [3:0] REVISION = 4'h1   // arbitrary identity value
) (
    input  wire logic        mclk,          // management clock
    input  wire logic        nrst,          // synchronous reset, low
    input  wire logic [2:0]  mode_strap,    // mode straps
    input  wire logic [4:0]  phy_addr,      // own management address
    input  wire logic        mdc,           // management data clock
    input  wire logic        mdio_i,        // management data in
    output logic             mdio_o,        // management data out
    output logic             mdio_oe,       // high while driving mdio
    input  wire logic        an_restart,    // negotiation restarted
    input  wire logic        an_done,       // negotiation complete
    input  wire logic        lcw_valid,     // partner code word strobe
    input  wire logic [15:0] lcw_data,      // partner code word
    output logic      [15:0] adv_word,      // local page to advertise
    output logic      [15:0] partner_word,  // partner ability view
    output logic             pause_sym_en,  // symmetric pause active
    output logic             pause_asym_en  // asymmetric pause active
);
    import pka_pkg::*;

    pka_state_t  state_q;
    logic        mdc_q;
    logic        rise;
    logic [5:0]  pre_cnt_q;
    logic [4:0]  cnt_q;
    logic [12:0] hdr_q;
    logic [12:0] hdr_d;
    logic [15:0] wdat_q;
    logic [15:0] wdat_d;
    logic [15:0] rsh_q;
    logic        hit_q;
    logic        hdr_hit;
    logic        hdr_mapped;
    logic [4:0]  hdr_idx;
    logic [1:0]  hdr_op;
    logic        wr_pulse;
    logic [4:0]  wr_idx_q;
    logic [15:0] ident_q;
    logic [15:0] adv_q;
    logic [15:0] rd_data;
    logic [2:0]  strap_abil;

    // management clock rising edge, seen one mclk after it happens;
    // mdc idles high, so the history resets high to avoid a false rise
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mdc_q <= 1'b1;
        end else begin
            mdc_q <= mdc;
        end
    end

    assign rise = mdc && !mdc_q;

    // header and write data shift in msb first
    assign hdr_d      = {hdr_q[11:0], mdio_i};
    assign wdat_d     = {wdat_q[14:0], mdio_i};
    assign hdr_op     = hdr_d[11:10];
    assign hdr_idx    = hdr_d[4:0];
    assign hdr_hit    = (hdr_d[9:5] == phy_addr);
    assign hdr_mapped = (hdr_idx == IDX_IDENT_LOW)
                     || (hdr_idx == IDX_ADVERTISE)
                     || (hdr_idx == IDX_PARTNER);

    // frame sequencer: preamble, header, turnaround, data
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_q   <= PKA_S_PRE;
            pre_cnt_q <= 6'h00;
            cnt_q     <= 5'h00;
            hit_q     <= 1'b0;
        end else if (rise) begin
            case (state_q)
                PKA_S_PRE: begin
                    cnt_q <= 5'h00;
                    if (mdio_i) begin
                        if (pre_cnt_q != PRE_LEN) begin
                            pre_cnt_q <= pre_cnt_q + 6'h01;
                        end
                    end else begin
                        pre_cnt_q <= 6'h00;
                        // first start bit after a full preamble
                        if (pre_cnt_q == PRE_LEN) begin
                            state_q <= PKA_S_HDR;
                        end
                    end
                end
                PKA_S_HDR: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == HDR_LAST) begin
                        cnt_q <= 5'h00;
                        hit_q <= hdr_hit && hdr_mapped;
                        if (!hdr_d[12]) begin
                            state_q <= PKA_S_PRE;
                        end else if (hdr_op == OP_READ
                                     && hdr_hit && hdr_mapped) begin
                            state_q <= PKA_S_TA;
                        end else if (hdr_op == OP_WRITE) begin
                            state_q <= PKA_S_WTA;
                        end else begin
                            state_q <= PKA_S_PRE;
                        end
                    end
                end
                PKA_S_TA: begin
                    state_q <= PKA_S_RDATA;
                end
                PKA_S_RDATA: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == DATA_BITS) begin
                        cnt_q   <= 5'h00;
                        state_q <= PKA_S_PRE;
                    end
                end
                PKA_S_WTA: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == TA_LAST) begin
                        cnt_q   <= 5'h00;
                        state_q <= PKA_S_WDATA;
                    end
                end
                PKA_S_WDATA: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == DATA_BITS - 5'h01) begin
                        cnt_q   <= 5'h00;
                        state_q <= PKA_S_PRE;
                    end
                end
                default: begin
                    state_q <= PKA_S_PRE;
                end
            endcase
        end
    end

    // header and write data shifters
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            hdr_q  <= 13'h0000;
            wdat_q <= 16'h0000;
        end else if (rise) begin
            if (state_q == PKA_S_HDR) begin
                hdr_q <= hdr_d;
            end
            if (state_q == PKA_S_WDATA) begin
                wdat_q <= wdat_d;
            end
        end
    end

    // register index of the current frame
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wr_idx_q <= 5'h00;
        end else if (rise && state_q == PKA_S_HDR && cnt_q == HDR_LAST)
        begin
            wr_idx_q <= hdr_idx;
        end
    end

    // a write lands on the rise that samples the last data bit
    assign wr_pulse = rise && (state_q == PKA_S_WDATA)
                   && (cnt_q == DATA_BITS - 5'h01) && hit_q;

    // read data mux; unlisted indices select zero, but reads of them are never answered
    always_comb begin
        case (wr_idx_q)
            IDX_IDENT_LOW: rd_data = ident_q;
            IDX_ADVERTISE: rd_data = adv_q;
            IDX_PARTNER:   rd_data = partner_word;
            default:       rd_data = 16'h0000;
        endcase
    end

    // read driver: zero in the second turnaround bit, then 16 bits
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mdio_oe <= 1'b0;
            mdio_o  <= 1'b0;
            rsh_q   <= 16'h0000;
        end else if (rise) begin
            case (state_q)
                PKA_S_TA: begin
                    mdio_oe <= 1'b1;
                    mdio_o  <= 1'b0;
                    rsh_q   <= rd_data;
                end
                PKA_S_RDATA: begin
                    if (cnt_q == DATA_BITS) begin
                        mdio_oe <= 1'b0;
                        mdio_o  <= 1'b0;
                    end else begin
                        mdio_o <= rsh_q[15];
                        rsh_q  <= {rsh_q[14:0], 1'b0};
                    end
                end
                default: begin
                    mdio_oe <= 1'b0;
                    mdio_o  <= 1'b0;
                end
            endcase
        end
    end

    // strap decode: all-capable strap offers every duplex ability
    assign strap_abil = (mode_strap == STRAP_ALL) ? 3'h7 : 3'h0;

    // second identifier register, fully writable
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ident_q[15:ID_ORG_LSB]            <= ORG_BITS;
            ident_q[ID_ORG_LSB-1:ID_MODEL_LSB] <= MODEL;
            ident_q[ID_MODEL_LSB-1:ID_REV_LSB] <= REVISION;
        end else if (wr_pulse && wr_idx_q == IDX_IDENT_LOW) begin
            ident_q <= wdat_d;
        end
    end

    // advertisement register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            adv_q            <= ADV_RESET_BASE;
            adv_q[ADV_100FD] <= strap_abil[2];
            adv_q[ADV_10FD]  <= strap_abil[1];
            adv_q[ADV_10]    <= strap_abil[0];
        end else if (wr_pulse && wr_idx_q == IDX_ADVERTISE) begin
            adv_q <= wdat_d & ADV_WR_MASK;
        end
    end

    assign adv_word = adv_q;

    // partner view is written only by received code words and cleared by restart
    pka_partner_latch u_partner (
        .mclk       (mclk),
        .nrst       (nrst),
        .an_restart (an_restart),
        .lcw_valid  (lcw_valid),
        .lcw_data   (lcw_data),
        .lp_word    (partner_word)
    );

    pka_pause_resolve u_pause (
        .mclk          (mclk),
        .nrst          (nrst),
        .an_done       (an_done),
        .local_pause   (adv_q[ADV_PAUSE_LSB+1:ADV_PAUSE_LSB]),
        .partner_pause (partner_word[LP_PAUSE]),
        .pause_sym_en  (pause_sym_en),
        .pause_asym_en (pause_asym_en)
    );
endmodule
